// ### design/mpo_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`include "mpo_defines.svh"

module mpo_fifo
  import mpo_pkg::*;
#(
  parameter int unsigned WIDTH = `MPO_FIFO_WIDTH,
  parameter int unsigned DEPTH = `MPO_FIFO_DEPTH
)
(
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_wr_valid, // Write request
  output logic o_wr_ready, // Room for a word
  input wire logic [WIDTH-1:0] i_wr_data, // Write word
  output logic o_rd_valid, // Word available
  input wire logic i_rd_ready, // Reader takes word
  output logic [WIDTH-1:0] o_rd_data // Head word
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wptr;
  logic [AW:0] rptr;

  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire do_wr = i_wr_valid && !full;
  wire do_rd = i_rd_ready && !empty;

  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign o_rd_data = mem[rptr[AW-1:0]];

  always_ff @(posedge i_mclk)
  begin
    if (do_wr)
    begin
      mem[wptr[AW-1:0]] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule : mpo_fifo

// ### design/mpo_otp_seq.sv
// Serial command sequencer: dual/quad page program and one-time areas
`timescale 1ns/100ps
`include "mpo_defines.svh"

module mpo_otp_seq
  import mpo_pkg::*;
#(
  parameter int unsigned ERASE_TIME_US = 1000, // Area erase time
  parameter int unsigned PROG_TIME_US = 100 // Program time
)
(
  input wire logic i_mclk, // System clock, 25 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_sclk, // Serial clock from host
  input wire logic i_cs_n, // Chip select, active low
  input wire logic [3:0] i_io, // Data lines in
  output logic [3:0] o_io, // Data lines out
  output logic [3:0] o_io_oe, // Data line drive enables
  input wire logic i_quad_lines_enable, // Quad enable config bit
  input wire logic [4:0] i_block_protect_bits, // Block protection bits
  input wire logic [2:0] i_otp_area_lock_bits, // Area lock bits
  output logic o_busy_flag, // Self-timed cycle running
  output logic o_write_latch, // Write latch
  output logic o_pgm_valid, // Main array program word valid
  input wire logic i_pgm_ready, // Main array accepts word
  output logic [23:0] o_pgm_addr, // Main array byte address
  output logic [7:0] o_pgm_data // Data to AND into array
);

  localparam int unsigned ERASE_CYC = ERASE_TIME_US * `MPO_CLK_MHZ;
  localparam int unsigned PROG_CYC = PROG_TIME_US * `MPO_CLK_MHZ;

  // ========================================================================
  // Decode helpers
  function automatic logic mpo_otp_addr_ok(input logic [23:0] a);
    return (a[23:16] == 8'h00) && (a[15:12] >= `MPO_AREA_FIRST) &&
           (a[15:12] <= `MPO_AREA_LAST_SEL) && (a[11:10] == 2'h0);
  endfunction : mpo_otp_addr_ok

  // Top blocks are protected; count doubles with each step of the code up to 6, and code 7 protects all
  function automatic logic mpo_is_protected(input logic [23:0] a, input logic [4:0] bp);
    logic [7:0] first;
    first = `MPO_BLK_COUNT - (`MPO_BLK_ONE << (bp[2:0] - `MPO_BP_STEP));
    return (bp[2:0] == `MPO_BP_ALL) ||
           ((bp[2:0] != `MPO_BP_NONE) && ({1'b0, a[22:16]} >= first));
  endfunction : mpo_is_protected

  // ========================================================================
  // Input synchronisers
  logic [2:0] sclk_sy;
  logic [2:0] cs_sy;
  logic [3:0] io_sy1;
  logic [3:0] io_sy2;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      sclk_sy <= 3'h0;
      cs_sy <= 3'h7;
      io_sy1 <= 4'h0;
      io_sy2 <= 4'h0;
    end
    else
    begin
      sclk_sy <= {sclk_sy[1:0], i_sclk};
      cs_sy <= {cs_sy[1:0], i_cs_n};
      io_sy1 <= i_io;
      io_sy2 <= io_sy1;
    end
  end

  wire sclk_rise = sclk_sy[1] && !sclk_sy[2];
  wire sclk_fall = !sclk_sy[1] && sclk_sy[2];
  wire cs_high = cs_sy[1];
  wire cs_rise = cs_sy[1] && !cs_sy[2];

  // ========================================================================
  // Frame state and storage
  mpo_phase_t phase;
  mpo_exec_t exec;
  logic [7:0] cmd;
  logic [7:0] sh;
  logic [3:0] bitcnt;
  logic [1:0] bytecnt;
  logic [23:0] addr;
  logic [9:0] woff;
  logic [9:0] roff;
  logic got_data;
  logic [7:0] cur;
  logic [2:0] ocnt;
  logic [7:0] pbuf [0:`MPO_BUF_WORDS-1];
  logic [`MPO_BUF_WORDS-1:0] pval;
  logic [7:0] otp_mem [0:`MPO_OTP_WORDS-1];
  logic [23:0] xaddr;
  logic [9:0] xidx;
  logic [`MPO_TMR_W-1:0] tmr;

  // ========================================================================
  // Shift path decode
  wire in_dual = (phase == P_DATA) && (cmd == `MPO_OP_DUAL);
  wire in_quad = (phase == P_DATA) && (cmd == `MPO_OP_QUAD);
  wire [3:0] lane_n = in_quad ? `MPO_LANE4 : (in_dual ? `MPO_LANE2 : `MPO_LANE1);
  wire [7:0] next_sh = in_quad ? {sh[3:0], io_sy2} :
                       (in_dual ? {sh[5:0], io_sy2[1:0]} : {sh[6:0], io_sy2[0]});
  wire [3:0] next_bitcnt = bitcnt + lane_n;
  wire shifting = sclk_rise && !cs_high && (phase != P_OUT) && (phase != P_DEAD);
  wire byte_done = shifting && (next_bitcnt == `MPO_BYTE_BITS);
  wire [23:0] next_addr = {addr[15:0], next_sh};
  wire is_page_cmd = (cmd == `MPO_OP_DUAL) || (cmd == `MPO_OP_QUAD);
  wire busy = o_busy_flag;
  wire wl = o_write_latch;

  wire op_wren = (next_sh == `MPO_OP_WREN) && !busy;
  wire op_sr = (next_sh == `MPO_OP_RDSR);
  wire op_dual = (next_sh == `MPO_OP_DUAL) && wl && !busy;
  wire op_quad = (next_sh == `MPO_OP_QUAD) && wl && i_quad_lines_enable && !busy;
  wire op_otp = ((next_sh == `MPO_OP_OTP_ERASE) || (next_sh == `MPO_OP_OTP_WRITE)) &&
                wl && !busy;
  wire op_rd = (next_sh == `MPO_OP_OTP_READ) && !busy;
  wire op_prog = op_dual || op_quad || (op_otp && (next_sh == `MPO_OP_OTP_WRITE));
  wire cmd_done = byte_done && (phase == P_CMD);
  wire wren_hit = cmd_done && op_wren;

  wire [1:0] area_m1 = addr[13:12] - `MPO_AREA_BASE;
  wire otp_ok = mpo_otp_addr_ok(addr);
  wire area_locked = i_otp_area_lock_bits[area_m1];
  wire [9:0] roff_inc = roff + `MPO_OFF_STEP;
  wire [7:0] rd_byte = otp_ok ? otp_mem[{area_m1, roff}] : `MPO_ERASED;
  wire [7:0] rd_next = otp_ok ? otp_mem[{area_m1, roff_inc}] : `MPO_ERASED;
  wire [7:0] status_byte = {6'h00, wl, busy};

  // Execution starts only at an exact byte boundary of the frame
  wire frame_ok = cs_rise && (phase == P_DATA) && (bitcnt == 4'h0) && (exec == X_IDLE);
  wire start_erase = frame_ok && (cmd == `MPO_OP_OTP_ERASE) && !got_data &&
                     otp_ok && !area_locked;
  wire start_otpw = frame_ok && (cmd == `MPO_OP_OTP_WRITE) && got_data &&
                    otp_ok && !area_locked;
  wire start_page = frame_ok && is_page_cmd && got_data &&
                    !mpo_is_protected(addr, i_block_protect_bits);

  // ========================================================================
  // Serial frame engine
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || cs_high)
    begin
      phase <= P_CMD;
      bitcnt <= 4'h0;
      bytecnt <= 2'h0;
      got_data <= 1'b0;
      ocnt <= 3'h0;
      o_io_oe <= 4'h0;
      if (i_rst)
      begin
        cmd <= 8'h00;
        sh <= 8'h00;
        addr <= 24'h000000;
        woff <= 10'h000;
        roff <= 10'h000;
        cur <= 8'h00;
        o_io <= 4'h0;
        pval <= '0;
      end
    end
    else if (shifting)
    begin
      sh <= next_sh;
      bitcnt <= byte_done ? 4'h0 : next_bitcnt;
      if (byte_done)
      begin
        case (phase)
          P_CMD:
          begin
            cmd <= next_sh;
            if (op_prog)
            begin
              pval <= '0;
            end
            if (op_sr)
            begin
              phase <= P_OUT;
              cur <= status_byte;
              o_io_oe <= 4'h2;
            end
            else if (op_dual || op_quad || op_otp || op_rd)
            begin
              phase <= P_ADDR;
            end
            else
            begin
              phase <= P_DEAD;
            end
          end
          P_ADDR:
          begin
            addr <= next_addr;
            bytecnt <= bytecnt + 2'h1;
            if (bytecnt == `MPO_ADDR_BYTES_LAST)
            begin
              phase <= (cmd == `MPO_OP_OTP_READ) ? P_DUMMY : P_DATA;
              woff <= is_page_cmd ? {2'h0, next_sh} : next_addr[9:0];
              roff <= next_addr[9:0];
            end
          end
          P_DUMMY:
          begin
            phase <= P_OUT;
            cur <= rd_byte;
            o_io_oe <= 4'h2;
          end
          P_DATA:
          begin
            pbuf[woff] <= next_sh;
            pval[woff] <= 1'b1;
            got_data <= 1'b1;
            woff <= is_page_cmd ? {2'h0, woff[7:0] + 8'h01} : woff + `MPO_OFF_STEP;
          end
          default:
          begin
            phase <= P_DEAD;
          end
        endcase
      end
    end
    else if (sclk_fall && (phase == P_OUT))
    begin
      o_io <= {2'h0, cur[7], 1'b0};
      cur <= {cur[6:0], 1'b0};
      ocnt <= ocnt + 3'h1;
      if (ocnt == `MPO_OUT_BIT_LAST)
      begin
        roff <= roff_inc;
        cur <= (cmd == `MPO_OP_RDSR) ? status_byte : rd_next;
      end
    end
  end

  // ========================================================================
  // Self-timed cycles
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic [31:0] fifo_rd_data;
  wire [1:0] x_area = xaddr[13:12] - `MPO_AREA_BASE;
  wire fifo_push = (exec == X_PAGE) && pval[xidx];
  wire page_step = (exec == X_PAGE) && (!pval[xidx] || fifo_wr_ready);
  wire out_load = fifo_rd_valid && (!o_pgm_valid || i_pgm_ready);

  always_ff @(posedge i_mclk)
  begin
    case (exec)
      X_ERASE:
      begin
        otp_mem[{x_area, xidx}] <= `MPO_ERASED;
      end
      X_OTPW:
      begin
        if (pval[xidx])
        begin
          otp_mem[{x_area, xidx}] <= otp_mem[{x_area, xidx}] & pbuf[xidx];
        end
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      exec <= X_IDLE;
      o_busy_flag <= 1'b0;
      o_write_latch <= 1'b0;
      xaddr <= 24'h000000;
      xidx <= 10'h000;
      tmr <= '0;
    end
    else
    begin
      if (wren_hit)
      begin
        o_write_latch <= 1'b1;
      end
      case (exec)
        X_IDLE:
        begin
          xidx <= 10'h000;
          xaddr <= addr;
          if (start_erase || start_otpw || start_page)
          begin
            o_busy_flag <= 1'b1;
            exec <= start_erase ? X_ERASE : (start_otpw ? X_OTPW : X_PAGE);
          end
        end
        X_ERASE, X_OTPW:
        begin
          xidx <= xidx + `MPO_OFF_STEP;
          if (xidx == `MPO_AREA_LAST)
          begin
            exec <= X_TIME;
            tmr <= (exec == X_ERASE) ? `MPO_TMR_W'(ERASE_CYC) : `MPO_TMR_W'(PROG_CYC);
          end
        end
        X_PAGE:
        begin
          if (page_step)
          begin
            xidx <= xidx + `MPO_OFF_STEP;
            if (xidx == `MPO_PAGE_LAST)
            begin
              exec <= X_DRAIN;
            end
          end
        end
        X_DRAIN:
        begin
          if (!fifo_rd_valid && !o_pgm_valid)
          begin
            exec <= X_TIME;
            tmr <= `MPO_TMR_W'(PROG_CYC);
          end
        end
        X_TIME:
        begin
          tmr <= tmr - `MPO_TMR_STEP;
          if (tmr <= `MPO_TMR_STEP)
          begin
            exec <= X_IDLE;
            o_busy_flag <= 1'b0;
            o_write_latch <= 1'b0;
          end
        end
        default:
        begin
          exec <= X_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Main array program path; the array ANDs data into erased cells
  mpo_fifo #(
    .WIDTH(`MPO_FIFO_WIDTH),
    .DEPTH(`MPO_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_wr_valid(fifo_push),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data({xaddr[23:8], xidx[7:0], pbuf[xidx]}),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(out_load),
    .o_rd_data(fifo_rd_data)
  );

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_pgm_valid <= 1'b0;
      o_pgm_addr <= 24'h000000;
      o_pgm_data <= 8'h00;
    end
    else if (out_load)
    begin
      o_pgm_valid <= 1'b1;
      o_pgm_addr <= fifo_rd_data[31:8];
      o_pgm_data <= fifo_rd_data[7:0];
    end
    else if (i_pgm_ready)
    begin
      o_pgm_valid <= 1'b0;
    end
  end

endmodule : mpo_otp_seq

// ### inc/mpo_defines.svh
// Constants for the multi-line program and one-time-area command sequencer
`ifndef MPO_DEFINES_SVH
`define MPO_DEFINES_SVH

// ==========================================================================
// Clock
`define MPO_CLK_MHZ 25

// ==========================================================================
// Opcodes
`define MPO_OP_WREN 8'h06
`define MPO_OP_RDSR 8'h05
`define MPO_OP_DUAL 8'hA2
`define MPO_OP_QUAD 8'h32
`define MPO_OP_OTP_ERASE 8'h44
`define MPO_OP_OTP_WRITE 8'h42
`define MPO_OP_OTP_READ 8'h48

// ==========================================================================
// Framing
`define MPO_BYTE_BITS 4'h8
`define MPO_LANE1 4'h1
`define MPO_LANE2 4'h2
`define MPO_LANE4 4'h4
`define MPO_ADDR_BYTES_LAST 2'h2
`define MPO_OUT_BIT_LAST 3'h7

// ==========================================================================
// Memory geometry
`define MPO_BUF_WORDS 1024
`define MPO_OTP_WORDS 3072
`define MPO_PAGE_LAST 10'h0FF
`define MPO_AREA_LAST 10'h3FF
`define MPO_OFF_STEP 10'h001
`define MPO_ERASED 8'hFF
`define MPO_AREA_FIRST 4'h1
`define MPO_AREA_LAST_SEL 4'h3
`define MPO_AREA_BASE 2'h1
`define MPO_FIFO_DEPTH 16
`define MPO_FIFO_WIDTH 32

// ==========================================================================
// Protection decode
`define MPO_BLK_COUNT 8'h80
`define MPO_BLK_ONE 8'h01
`define MPO_BP_NONE 3'h0
`define MPO_BP_ALL 3'h7
`define MPO_BP_STEP 3'h1

// ==========================================================================
// Timer
`define MPO_TMR_W 24
`define MPO_TMR_STEP 24'h000001

`endif

// ### inc/mpo_pkg.sv
// Types shared by the sequencer modules
package mpo_pkg;

  // ========================================================================
  // Serial frame phase
  typedef enum logic [2:0] {
    P_CMD,
    P_ADDR,
    P_DUMMY,
    P_DATA,
    P_OUT,
    P_DEAD
  } mpo_phase_t;

  // ========================================================================
  // Self-timed cycle
  typedef enum logic [2:0] {
    X_IDLE,
    X_ERASE,
    X_OTPW,
    X_PAGE,
    X_DRAIN,
    X_TIME
  } mpo_exec_t;

endpackage : mpo_pkg

// ### verification/mpo_host.sv
// Host controller model for the serial bus
`timescale 1ns/100ps
// ====================
// Host
module mpo_host
  import mpo_pkg::*;
(
  input wire logic i_mclk, // System clock
  output logic o_sclk, // Serial clock, still between frames
  output logic o_cs_n, // Select
  output logic [3:0] o_io, // Data lines
  input wire logic i_so // Resolved serial out line
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick

  // Select stays low across the whole command
  task automatic open_frame;
    tick(1);
    o_cs_n <= 1'b0;
    tick(4);
  endtask : open_frame

  // Released lines show the inverse so stale values never pass
  task automatic close_frame;
    tick(4);
    o_cs_n <= 1'b1;
    o_io <= ~o_io;
    tick(12);
  endtask : close_frame

  task automatic shift(input logic [7:0] b, input int lanes, input int beats,
    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < beats; i++)
    begin
      case (lanes)
        1: o_io <= {~o_io[3:1], b[7 - i]};
        2: o_io <= {~o_io[3:2], b[7 - 2 * i -: 2]};
        default: o_io <= b[7 - 4 * i -: 4];
      endcase
      tick(4);
      o_sclk <= 1'b1;
      tick(4);
      rx = {rx[6:0], i_so};
      o_sclk <= 1'b0;
    end
  endtask : shift
endmodule : mpo_host

// ### verification/mpo_otp_seq_sva.sv
// Port assertions for the serial command sequencer
`timescale 1ns/100ps
// ====================
// Checker
module mpo_otp_seq_sva
  import mpo_pkg::*;
#(
  parameter int unsigned ERASE_TIME_US = 1000, // Area erase time
  parameter int unsigned PROG_TIME_US = 100 // Program time
)
(
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_sclk, // Serial clock
  input wire logic i_cs_n, // Select
  input wire logic [3:0] i_io, // Lines in
  input wire logic [3:0] o_io, // Lines out
  input wire logic [3:0] o_io_oe, // Line enables
  input wire logic i_quad_lines_enable, // Quad enable
  input wire logic [4:0] i_block_protect_bits, // Protection
  input wire logic [2:0] i_otp_area_lock_bits, // Area locks
  input wire logic o_busy_flag, // Busy
  input wire logic o_write_latch, // Write latch
  input wire logic o_pgm_valid, // Word valid
  input wire logic i_pgm_ready, // Word taken
  input wire logic [23:0] o_pgm_addr, // Word address
  input wire logic [7:0] o_pgm_data // Word data
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_pgm_hold: assert property (o_pgm_valid && !i_pgm_ready |=> o_pgm_valid
    && $stable(o_pgm_addr) && $stable(o_pgm_data)) else $error("Word changed while stalled");
  chk_pgm_busy: assert property (o_pgm_valid |-> o_busy_flag)
    else $error("Word offered while idle");
  chk_busy_cause: assert property ($rose(o_busy_flag) |-> o_write_latch && i_cs_n)
    else $error("Cycle started without latch or with select low");
  chk_busy_min: assert property ($rose(o_busy_flag) |=> o_busy_flag [*8])
    else $error("Busy dropped too early");
  chk_busy_end: assert property ($fell(o_busy_flag) |-> !o_write_latch)
    else $error("Latch still set after cycle");
  chk_latch_kept: assert property (o_busy_flag && o_write_latch |=>
    o_write_latch || !o_busy_flag) else $error("Latch lost mid cycle");
  chk_latch_set: assert property ($rose(o_write_latch) |-> !o_busy_flag && !i_cs_n)
    else $error("Latch set outside a frame or while busy");
  chk_oe_idle: assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
    else $error("Line driven while deselected");
  chk_line_one: assert property (o_io_oe[3:2] == 2'h0 && !o_io_oe[0] && !o_io[0])
    else $error("Unexpected output line");
  chk_prot_all: assert property (o_pgm_valid |-> i_block_protect_bits[2:0] != 3'h7)
    else $error("Word emitted while all protected");
endmodule : mpo_otp_seq_sva

bind mpo_otp_seq mpo_otp_seq_sva #(.ERASE_TIME_US(ERASE_TIME_US), .PROG_TIME_US(PROG_TIME_US))
  u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_io(i_io),
  .o_io(o_io), .o_io_oe(o_io_oe), .i_quad_lines_enable(i_quad_lines_enable),
  .i_block_protect_bits(i_block_protect_bits), .i_otp_area_lock_bits(i_otp_area_lock_bits),
  .o_busy_flag(o_busy_flag), .o_write_latch(o_write_latch), .o_pgm_valid(o_pgm_valid),
  .i_pgm_ready(i_pgm_ready), .o_pgm_addr(o_pgm_addr), .o_pgm_data(o_pgm_data));

// ### verification/multi_io_program_and_otp_sector_cmds_test.sv
// Self-checking bench for the serial command sequencer
`timescale 1ns/100ps
// ====================
// Bench
module multi_io_program_and_otp_sector_cmds_test
  import mpo_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic qe = 1'b0;
  logic [4:0] bp = 5'h00;
  logic [2:0] lock = 3'h0;
  logic ready = 1'b1;
  logic sclk, cs_n, so, busy, latch, pv, oe_seen;
  logic [3:0] io, dio, doe;
  logic [23:0] pa;
  logic [7:0] pd;
  logic [7:0] dat [0:31];
  logic [7:0] rx_q [$];
  logic [31:0] got_q [$];
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  initial forever #20 i_mclk = ~i_mclk;
  assign so = doe[1] ? dio[1] : io[1];

  mpo_otp_seq #(.ERASE_TIME_US(1), .PROG_TIME_US(1)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_io({io[3:2], so, io[0]}), .o_io(dio), .o_io_oe(doe),
    .i_quad_lines_enable(qe), .i_block_protect_bits(bp), .i_otp_area_lock_bits(lock),
    .o_busy_flag(busy), .o_write_latch(latch), .o_pgm_valid(pv), .i_pgm_ready(ready),
    .o_pgm_addr(pa), .o_pgm_data(pd));
  mpo_host u_host (.i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(io), .i_so(so));

  // ====================
  // Monitors and timeout
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (pv === 1'b1 && ready === 1'b1) got_q.push_back({pa, pd});
    if (doe !== 4'h0) oe_seen <= 1'b1;
    if (cyc == 40000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na, input int n,
    input int lanes, input int tail, input int rdn);
    logic [7:0] rx;
    u_host.open_frame();
    u_host.shift(op, 1, 8, rx);
    for (int k = 0; k < na; k++) u_host.shift(a[23 - 8 * k -: 8], 1, 8, rx);
    for (int k = 0; k < n; k++) u_host.shift(dat[k], lanes, 8 / lanes, rx);
    if (tail > 0) u_host.shift(8'hFF, lanes, tail, rx);
    for (int k = 0; k < rdn; k++)
    begin
      u_host.shift(8'hFF, 1, 8, rx);
      rx_q.push_back(rx);
    end
    u_host.close_frame();
  endtask : frame

  task automatic wren;
    frame(8'h06, 24'h000000, 0, 0, 1, 0, 0);
  endtask : wren

  task automatic wait_idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge i_mclk);
  endtask : wait_idle

  // ====================
  // Scenarios
  task automatic t_dual;
    check(32'({busy, latch, pv, doe}), 32'h0);
    for (int k = 0; k < 20; k++) dat[k] = 8'h30 + 8'(k);
    frame(8'hA2, 24'h0012F8, 3, 20, 2, 0, 0);
    check(32'(busy), 32'h0);
    wren();
    check(32'(latch), 32'h1);
    ready <= 1'b0;
    got_q.delete();
    frame(8'hA2, 24'h0012F8, 3, 20, 2, 0, 0);
    check(32'(busy), 32'h1);
    repeat (400) @(posedge i_mclk);
    check(32'(got_q.size()), 32'h0);
    check(32'(pv), 32'h1);
    ready <= 1'b1;
    wait_idle();
    check(32'(latch), 32'h0);
    check(32'(got_q.size()), 32'h14);
    for (int j = 0; j < 20; j++)
      check(got_q[j], {16'h0012, 8'hF8 + 8'((j + 8) % 20), dat[(j + 8) % 20]});
  endtask : t_dual

  task automatic t_quad;
    dat[0] = 8'hC3;
    wren();
    frame(8'h32, 24'h003400, 3, 1, 4, 0, 0);
    check(32'(busy), 32'h0);
    qe <= 1'b1;
    bp <= 5'h07;
    frame(8'h32, 24'h003400, 3, 1, 4, 0, 0);
    check(32'(busy), 32'h0);
    frame(8'hA2, 24'h003400, 3, 1, 2, 0, 0);
    check(32'(busy), 32'h0);
    bp <= 5'h00;
    frame(8'hA2, 24'h003400, 3, 1, 2, 2, 0);
    check(32'(busy), 32'h0);
    got_q.delete();
    frame(8'h32, 24'h003400, 3, 1, 4, 0, 0);
    check(32'(busy), 32'h1);
    wait_idle();
    check(32'(got_q.size()), 32'h1);
    check(got_q[0], 32'h003400C3);
  endtask : t_quad

  task automatic t_otp;
    wren();
    frame(8'h44, 24'h002000, 3, 0, 1, 1, 0);
    check(32'(busy), 32'h0);
    frame(8'h44, 24'h004000, 3, 0, 1, 0, 0);
    check(32'(busy), 32'h0);
    frame(8'h44, 24'h002000, 3, 0, 1, 0, 0);
    check(32'(busy), 32'h1);
    rx_q.delete();
    frame(8'h05, 24'h000000, 0, 0, 1, 0, 1);
    check(32'(rx_q[0]), 32'h03);
    oe_seen <= 1'b0;
    frame(8'h48, 24'h0023FE, 3, 0, 1, 8, 1);
    check(32'(oe_seen), 32'h0);
    check(32'(busy), 32'h1);
    wait_idle();
    check(32'(latch), 32'h0);
    dat[0] = 8'h11;
    dat[1] = 8'h22;
    dat[2] = 8'h33;
    wren();
    frame(8'h42, 24'h0023FE, 3, 3, 1, 0, 0);
    check(32'(busy), 32'h1);
    wait_idle();
    check(32'(latch), 32'h0);
    rx_q.delete();
    frame(8'h48, 24'h0023FE, 3, 0, 1, 8, 3);
    for (int j = 0; j < 3; j++) check(32'(rx_q[j]), 32'(dat[j]));
  endtask : t_otp

  task automatic t_lock;
    lock <= 3'h2;
    dat[0] = 8'h00;
    wren();
    frame(8'h44, 24'h002000, 3, 0, 1, 0, 0);
    check(32'(busy), 32'h0);
    frame(8'h42, 24'h0023FE, 3, 1, 1, 0, 0);
    check(32'(busy), 32'h0);
    frame(8'h44, 24'h001000, 3, 0, 1, 0, 0);
    check(32'(busy), 32'h1);
    wait_idle();
    rx_q.delete();
    frame(8'h48, 24'h0023FE, 3, 0, 1, 8, 1);
    check(32'(rx_q[0]), 32'h11);
  endtask : t_lock

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    oe_seen = 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    t_dual();
    t_quad();
    t_otp();
    t_lock();
    tally_and_finish();
  end
endmodule : multi_io_program_and_otp_sector_cmds_test
